// File: core/led_mode_mux.v
// led source selection for one switch port, registered outputs
// assumes the port status inputs are synchronous to hclk
`timescale 1ns/1ps
`default_nettype none
`include "switch_regs_consts.vh"

module led_mode_mux (
  // clock and reset
  input  wire       hclk,
  input  wire       hresetn,
  // mode from the control register
  input  wire [1:0] led_mode,
  // port status
  input  wire       port_speed_100,
  input  wire       port_link,
  input  wire       port_activity,
  input  wire       port_full_duplex,
  // led drive, 1 = lit
  output reg        port_led_output_one,
  output reg        port_led_output_zero
);

  reg led1_nxt;
  reg led0_nxt;
  reg lnkact;

  // link-with-activity blinks off while activity is seen
  always @*
  begin
    lnkact = port_link & ~port_activity;
    led1_nxt = 1'b0;
    led0_nxt = 1'b0;
    case (led_mode)
      `LED_MODE_SPD_LNKACT:
      begin
        led1_nxt = port_speed_100;
        led0_nxt = lnkact;
      end
      `LED_MODE_ACT_LNK:
      begin
        led1_nxt = port_activity;
        led0_nxt = port_link;
      end
      `LED_MODE_FDX_LNKACT:
      begin
        led1_nxt = port_full_duplex;
        led0_nxt = lnkact;
      end
      default:
      begin
        led1_nxt = port_full_duplex;
        led0_nxt = port_link;
      end
    endcase
  end

  // registered so the pins never glitch on a mode change
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      port_led_output_one  <= 1'b0;
      port_led_output_zero <= 1'b0;
    end
    else
    begin
      port_led_output_one  <= led1_nxt;
      port_led_output_zero <= led0_nxt;
    end
  end

endmodule
`default_nettype wire

// File: core/switch_unknown_da_pause_mac_regs.v
// register slice for unknown-destination forwarding, led mode and pause source address
// assumes one ahb-lite master, word transfers only, and a lookup engine on hclk
// Function
// - enable sends unknown destinations to default mask
// - three-bit rw default mask, resets all ones
// - mac address split high, mid, low words
// - pause frames use programmed mac address
// - low address word resets to all ones
// - two-bit led mode selects led sources
//
// Local design decision: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "switch_regs_consts.vh"

module switch_unknown_da_pause_mac_regs #(
  parameter        NUM_PORTS         = 3,
  // arbitrary neutral reset values for the upper address words
  parameter [15:0] PAUSE_SA_HIGH_RST = 16'h0200,
  parameter [15:0] PAUSE_SA_MID_RST  = 16'h0000
) (
  // clock and reset
  input  wire                 hclk,
  input  wire                 hresetn,
  // ahb-lite slave
  input  wire                 hsel,
  input  wire [7:0]           haddr,
  input  wire [1:0]           htrans,
  input  wire                 hwrite,
  input  wire [2:0]           hsize,
  input  wire [31:0]          hwdata,
  input  wire                 hready,
  output wire                 hreadyout,
  output wire                 hresp,
  output reg  [31:0]          hrdata,
  // lookup result from the address table
  input  wire                 lookup_valid,
  input  wire                 lookup_miss,
  input  wire [NUM_PORTS-1:0] lookup_port_mask,
  // forwarding decision
  output reg                  fwd_valid_r,
  output reg  [NUM_PORTS-1:0] fwd_port_mask_r,
  // pause generator
  input  wire                 pause_frame_start,
  output reg  [47:0]          pause_frame_sa_r,
  output wire [47:0]          switch_station_address,
  // port status for the leds, two phy ports
  input  wire [1:0]           port_speed_100,
  input  wire [1:0]           port_link,
  input  wire [1:0]           port_activity,
  input  wire [1:0]           port_full_duplex,
  output wire [1:0]           port_led_output_one,
  output wire [1:0]           port_led_output_zero
);

  // registers and their next values
  reg  [15:0] ctrl_r;
  reg  [15:0] ctrl_nxt;
  reg  [15:0] sa_high_r;
  reg  [15:0] sa_high_nxt;
  reg  [15:0] sa_mid_r;
  reg  [15:0] sa_mid_nxt;
  reg  [15:0] sa_low_r;
  reg  [15:0] sa_low_nxt;

  // pending write captured in the address phase
  reg                wr_pend_r;
  reg [`IDX_W-1:0]   wr_idx_r;

  wire               addr_take;
  wire [`IDX_W-1:0]  addr_idx;
  wire               unk_en;
  wire [1:0]         led_mode;
  wire [NUM_PORTS-1:0] dflt_mask;

  // index match on a word address
  function hit;
    input [`IDX_W-1:0] idx;
    input [`IDX_W-1:0] reg_idx;
    begin
      hit = (idx == reg_idx);
    end
  endfunction

  // read mux; unmapped indices read as zero, upper half always zero
  function [31:0] read_word;
    input [`IDX_W-1:0] idx;
    input [15:0]       ctrl;
    input [15:0]       hi;
    input [15:0]       mid;
    input [15:0]       lo;
    begin
      read_word = 32'h00000000;
      if (hit(idx, `IDX_CTRL))
        read_word = {16'h0000, ctrl};
      else if (hit(idx, `IDX_PAUSE_SA_HIGH))
        read_word = {16'h0000, hi};
      else if (hit(idx, `IDX_PAUSE_SA_MID))
        read_word = {16'h0000, mid};
      else if (hit(idx, `IDX_PAUSE_SA_LOW))
        read_word = {16'h0000, lo};
    end
  endfunction

  // zero wait states and always okay; nothing on this slave can stall
  assign hreadyout = 1'b1;
  assign hresp     = `HRESP_OKAY;

  assign addr_take = hsel & hready & htrans[`HTRANS_NONSEQ_BIT];
  assign addr_idx  = haddr[7:2];

  // address phase bookkeeping for writes
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      wr_idx_r  <= {`IDX_W{1'b0}};
    end
    else if (hready)
    begin
      wr_pend_r <= addr_take & hwrite;
      wr_idx_r  <= addr_idx;
    end
  end

  // write data lands in the data phase; unmapped writes are dropped
  always @*
  begin
    ctrl_nxt    = ctrl_r;
    sa_high_nxt = sa_high_r;
    sa_mid_nxt  = sa_mid_r;
    sa_low_nxt  = sa_low_r;
    if (wr_pend_r)
    begin
      if (hit(wr_idx_r, `IDX_CTRL))
        ctrl_nxt = hwdata[15:0] & `CTRL_WR_MASK;
      if (hit(wr_idx_r, `IDX_PAUSE_SA_HIGH))
        sa_high_nxt = hwdata[15:0];
      if (hit(wr_idx_r, `IDX_PAUSE_SA_MID))
        sa_mid_nxt = hwdata[15:0];
      if (hit(wr_idx_r, `IDX_PAUSE_SA_LOW))
        sa_low_nxt = hwdata[15:0];
    end
  end

  // register storage
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_r    <= `CTRL_RESET;
      sa_high_r <= PAUSE_SA_HIGH_RST;
      sa_mid_r  <= PAUSE_SA_MID_RST;
      sa_low_r  <= `PAUSE_SA_LOW_RESET;
    end
    else
    begin
      ctrl_r    <= ctrl_nxt;
      sa_high_r <= sa_high_nxt;
      sa_mid_r  <= sa_mid_nxt;
      sa_low_r  <= sa_low_nxt;
    end
  end

  // read data is sampled from the next values, so a read right after a
  // write to the same word already sees the new contents
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h00000000;
    else if (addr_take & ~hwrite)
      hrdata <= read_word(addr_idx, ctrl_nxt, sa_high_nxt, sa_mid_nxt, sa_low_nxt);
  end

  // field extraction
  assign unk_en    = ctrl_r[`CTRL_UNK_EN_BIT];
  assign led_mode  = ctrl_r[`CTRL_LED_MODE_HI:`CTRL_LED_MODE_LO];
  assign dflt_mask = ctrl_r[`CTRL_PORT_MASK_LO+NUM_PORTS-1:`CTRL_PORT_MASK_LO];

  // forwarding decision, one cycle after each lookup result
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      fwd_valid_r     <= 1'b0;
      fwd_port_mask_r <= {NUM_PORTS{1'b0}};
    end
    else
    begin
      fwd_valid_r <= lookup_valid;
      if (lookup_valid)
      begin
        if (lookup_miss & unk_en)
          fwd_port_mask_r <= dflt_mask;
        else
          fwd_port_mask_r <= lookup_port_mask;
      end
    end
  end

  // the live address, high word in the top bits
  assign switch_station_address = {sa_high_r, sa_mid_r, sa_low_r};

  // snapshot at frame start so a rewrite mid-frame cannot split the address
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pause_frame_sa_r <= {PAUSE_SA_HIGH_RST, PAUSE_SA_MID_RST, `PAUSE_SA_LOW_RESET};
    else if (pause_frame_start)
      pause_frame_sa_r <= switch_station_address;
  end

  // one led selector per phy port
  genvar p;
  generate
    for (p = 0; p < 2; p = p + 1)
    begin : g_led
      led_mode_mux u_led (
        .hclk                 (hclk),
        .hresetn              (hresetn),
        .led_mode             (led_mode),
        .port_speed_100       (port_speed_100[p]),
        .port_link            (port_link[p]),
        .port_activity        (port_activity[p]),
        .port_full_duplex     (port_full_duplex[p]),
        .port_led_output_one  (port_led_output_one[p]),
        .port_led_output_zero (port_led_output_zero[p])
      );
    end
  endgenerate

  // hsize is accepted but not checked: only whole-word transfers occur
  wire unused_ok = &{1'b0, hsize, hwdata[31:16], haddr[1:0]};

endmodule
`default_nettype wire

// File: pkg/switch_regs_consts.vh
// constants for the unknown-destination, led mode and pause source address registers
// assumes word-aligned registers on a 32-bit ahb-lite bus, byte address = 4 * index
`ifndef SWITCH_REGS_CONSTS_VH
`define SWITCH_REGS_CONSTS_VH

// register indices, haddr[7:2] carries the index
`define IDX_W               6
`define IDX_CTRL            6'h0E
`define IDX_PAUSE_SA_HIGH   6'h10
`define IDX_PAUSE_SA_MID    6'h12
`define IDX_PAUSE_SA_LOW    6'h14

// control register field positions
`define CTRL_LED_MODE_HI    9
`define CTRL_LED_MODE_LO    8
`define CTRL_UNK_EN_BIT     7
`define CTRL_PORT_MASK_HI   2
`define CTRL_PORT_MASK_LO   0
// bits that software can write; drive strength bits 6-5 are not held
`define CTRL_WR_MASK        16'hFF9F
`define CTRL_RESET          16'h0807

// pause source address reset values
`define PAUSE_SA_LOW_RESET  16'hFFFF

// led mode codes
`define LED_MODE_SPD_LNKACT 2'h0
`define LED_MODE_ACT_LNK    2'h1
`define LED_MODE_FDX_LNKACT 2'h2
`define LED_MODE_FDX_LNK    2'h3

// ahb-lite encodings
`define HTRANS_NONSEQ_BIT   1
`define HRESP_OKAY          1'h0

`endif

// File: tb/ahb_host_model.sv
// host side bus master model, single word transfers
// assumes hready is the slave hreadyout and the bench bounds hangs
`timescale 1ns/1ps
`default_nettype none
module ahb_host_model (
  // clock and answer
  input  wire         hclk,
  input  wire         hready,
  input  wire  [31:0] hrdata,
  // request
  output logic        hsel,
  output logic [7:0]  haddr,
  output logic [1:0]  htrans,
  output logic        hwrite,
  output logic [2:0]  hsize,
  output logic [31:0] hwdata
);
  initial
  begin
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // address phase held until hready, then data phase held until hready
  task xfer(input [7:0] a, input w, input [31:0] d, output [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (!hready) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (!hready) @(posedge hclk);
    q = hrdata;
  endtask
endmodule
`default_nettype wire

// File: tb/switch_unknown_da_pause_mac_regs_tb_top.sv
// bench for the register slice: bus, lookup, pause and led checks
// assumes the host model and the bound checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module switch_unknown_da_pause_mac_regs_tb_top;
  reg         hclk, hresetn, lk_v, lk_m, p_st;
  reg  [2:0]  lk_pm;
  reg  [1:0]  spd, lnk, act, fdx, m;
  wire        hsel, hwrite, hready, hresp, fwd_v;
  wire [7:0]  haddr;
  wire [1:0]  htrans, led1, led0;
  wire [2:0]  hsize, fwd_m;
  wire [31:0] hwdata, hrdata;
  wire [47:0] psa, sta;
  reg  [31:0] q;
  integer     bad_count = 0;
  integer     n_tests = 0;
  ahb_host_model ahb_host_model_inst (.hclk(hclk), .hready(hready), .hrdata(hrdata),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata));
  switch_unknown_da_pause_mac_regs switch_unknown_da_pause_mac_regs_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .lookup_valid(lk_v),
    .lookup_miss(lk_m), .lookup_port_mask(lk_pm), .fwd_valid_r(fwd_v),
    .fwd_port_mask_r(fwd_m), .pause_frame_start(p_st), .pause_frame_sa_r(psa),
    .switch_station_address(sta), .port_speed_100(spd), .port_link(lnk),
    .port_activity(act), .port_full_duplex(fdx), .port_led_output_one(led1),
    .port_led_output_zero(led0));
  initial
  begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  task stop_test;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task chk(input [47:0] s, input [47:0] e);
    n_tests = n_tests + 1;
    if (s !== e)
    begin
      bad_count = bad_count + 1;
      $display("[FAIL] %0t got %h want %h", $time, s, e);
    end
  endtask
  task rd(input [7:0] a, input [31:0] e);
    ahb_host_model_inst.xfer(a, 1'b0, 32'h0, q);
    chk(q, e);
  endtask
  task wr(input [7:0] a, input [31:0] d);
    ahb_host_model_inst.xfer(a, 1'b1, d, q);
  endtask
  // one lookup result, forward decision checked one cycle later
  task lk(input mi, input [2:0] pm, input [2:0] e);
    @(posedge hclk);
    lk_v <= 1'b1;
    lk_m <= mi;
    lk_pm <= pm;
    @(posedge hclk);
    lk_v <= 1'b0;
    #1 chk(fwd_v, 1'b1);
    chk(fwd_m, e);
  endtask
  // generous limit: the sequence needs under a hundred cycles
  initial
  begin
    #200000;
    bad_count = bad_count + 1;
    stop_test;
  end
  initial
  begin
    {hresetn, lk_v, lk_m, p_st, lk_pm} = 7'h00;
    // speed, activity and full duplex differ so every led code shows a different pattern
    {spd, lnk, act, fdx} = {2'h1, 2'h3, 2'h2, 2'h3};
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    rd(8'h38, 32'h0807);
    rd(8'h40, 32'h0200);
    rd(8'h48, 32'h0000);
    rd(8'h50, 32'hFFFF);
    rd(8'h3C, 32'h0000);
    chk(hresp, 1'b0);
    $display("test reset done");
    wr(8'h40, 32'hFFFF1234);
    wr(8'h48, 32'h5678);
    wr(8'h50, 32'h9ABC);
    rd(8'h40, 32'h1234);
    rd(8'h50, 32'h9ABC);
    rd(8'h48, 32'h5678);
    chk(sta, 48'h123456789ABC);
    @(posedge hclk) p_st <= 1'b1;
    @(posedge hclk) p_st <= 1'b0;
    #1 chk(psa, 48'h123456789ABC);
    wr(8'h50, 32'h0001);
    #1 chk(psa, 48'h123456789ABC);
    $display("test address done");
    wr(8'h38, 32'hFFFF);
    rd(8'h38, 32'hFF9F);
    wr(8'h38, 32'h0085);
    lk(1'b1, 3'h2, 3'h5);
    lk(1'b0, 3'h3, 3'h3);
    wr(8'h38, 32'h0005);
    lk(1'b1, 3'h2, 3'h2);
    $display("test forward done");
    // every led code, expected sources worked out per code
    m = 2'h0;
    repeat (4)
    begin
      wr(8'h38, {22'h0, m, 8'h07});
      repeat (2) @(posedge hclk);
      #1 chk(led1, m == 2'h0 ? spd : m == 2'h1 ? act : fdx);
      chk(led0, m[0] ? lnk : lnk & ~act);
      m = m + 2'h1;
    end
    // drop link on port 1 in code 11; its link led must go dark a cycle later
    @(posedge hclk) lnk <= 2'h1;
    repeat (2) @(posedge hclk);
    #1 chk(led0, 2'h1);
    $display("test led done");
    stop_test;
  end
endmodule
`default_nettype wire

// File: tb/unk_regs_chk_sva.sv
// checker for the register slice, sees only the slice ports
// assumes single word ahb-lite transfers and a bind onto the slice
`timescale 1ns/1ps
`default_nettype none
module unk_regs_chk #(
  parameter NUM_PORTS = 3
) (
  // clock and reset
  input wire                 hclk,
  input wire                 hresetn,
  // bus
  input wire                 hsel,
  input wire                 hready,
  input wire [1:0]           htrans,
  input wire                 hwrite,
  input wire [31:0]          hrdata,
  // lookup and pause
  input wire                 lookup_valid,
  input wire                 lookup_miss,
  input wire [NUM_PORTS-1:0] lookup_port_mask,
  input wire                 fwd_valid_r,
  input wire [NUM_PORTS-1:0] fwd_port_mask_r,
  input wire                 pause_frame_start,
  input wire [47:0]          pause_frame_sa_r,
  input wire [47:0]          switch_station_address,
  // leds
  input wire [1:0]           port_link,
  input wire [1:0]           port_led_output_zero
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // write data phase marker; the address may only move after one
  reg wr_dp_r;
  always @(posedge hclk or negedge hresetn)
    if (!hresetn)
      wr_dp_r <= 1'b0;
    else
      wr_dp_r <= hsel & hready & htrans[1] & hwrite;
  property p_vld; lookup_valid |=> fwd_valid_r; endproperty
  a_vld: assert property (p_vld) else $error("no forward pulse");
  property p_novld; !lookup_valid |=> !fwd_valid_r; endproperty
  a_novld: assert property (p_novld) else $error("stray forward pulse");
  property p_hit;
    lookup_valid && !lookup_miss |=> fwd_port_mask_r == $past(lookup_port_mask);
  endproperty
  a_hit: assert property (p_hit) else $error("hit mask altered");
  property p_pause;
    pause_frame_start |=> pause_frame_sa_r == $past(switch_station_address);
  endproperty
  a_pause: assert property (p_pause) else $error("pause source wrong");
  property p_phold; !pause_frame_start |=> $stable(pause_frame_sa_r); endproperty
  a_phold: assert property (p_phold) else $error("pause source moved");
  property p_sta; $changed(switch_station_address) |-> $past(wr_dp_r); endproperty
  a_sta: assert property (p_sta) else $error("address moved unwritten");
  // a lit link led needs link in the cycle before, in every mode
  property p_led; (port_led_output_zero & ~$past(port_link)) == 2'h0; endproperty
  a_led: assert property (p_led) else $error("led lit without link");
  property p_rdhi; hrdata[31:16] == 16'h0000; endproperty
  a_rdhi: assert property (p_rdhi) else $error("upper read half set");
  c_miss: cover property (lookup_valid && lookup_miss);
  c_pause: cover property (pause_frame_start);
  c_wr: cover property (wr_dp_r);
endmodule
bind switch_unknown_da_pause_mac_regs unk_regs_chk #(.NUM_PORTS(NUM_PORTS)) chk_inst (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .hready(hready), .htrans(htrans),
  .hwrite(hwrite), .hrdata(hrdata), .lookup_valid(lookup_valid),
  .lookup_miss(lookup_miss), .lookup_port_mask(lookup_port_mask),
  .fwd_valid_r(fwd_valid_r), .fwd_port_mask_r(fwd_port_mask_r),
  .pause_frame_start(pause_frame_start), .pause_frame_sa_r(pause_frame_sa_r),
  .switch_station_address(switch_station_address), .port_link(port_link),
  .port_led_output_zero(port_led_output_zero));
`default_nettype wire
